// ===== pkg/tsf_defines.svh
// constants of the transmit frame statistics block
// assumes a 32-bit register port with word-aligned byte addresses
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH
// ==========================================================
// counter indices and byte offsets
`define TSF_NUM_CNT 7
`define TSF_IDX_GOOD 3'h0
`define TSF_IDX_BCAST 3'h1
`define TSF_IDX_GROUP 3'h2
`define TSF_IDX_PAUSE 3'h3
`define TSF_IDX_DEFER 3'h4
`define TSF_IDX_COLL 3'h5
`define TSF_IDX_SCOLL 3'h6
`define TSF_OFF_GOOD 8'h00
`define TSF_OFF_BCAST 8'h04
`define TSF_OFF_GROUP 8'h08
`define TSF_OFF_PAUSE 8'h0C
`define TSF_OFF_DEFER 8'h10
`define TSF_OFF_COLL 8'h14
`define TSF_OFF_SCOLL 8'h18
// ==========================================================
// field values and reset values
`define TSF_CNT_W 32
`define TSF_CNT_RST 32'h0000_0000
`define TSF_BCAST_ADDR 48'hFFFF_FFFF_FFFF
`define TSF_GROUP_BIT 40
`define TSF_JAM_CYCLES 4
`endif

// ===== pkg/tsf_pkg.sv
// types of the transmit frame statistics block
// assumes tsf_defines.svh sits on the include path
package tsf_pkg;
  // ==========================================================
  // per-frame outcome report from the transmit path
  typedef struct packed {
    logic valid;         // one-cycle pulse, frame finished
    logic [47:0] dest;   // destination address
    logic mac_pause;     // pause frame built by the mac itself
    logic late_coll;     // frame met a late collision
    logic excess_coll;   // frame abandoned after too many collisions
    logic carrier_loss;  // carrier lost or never seen
    logic underrun;      // transmit data underrun
    logic deferred;      // medium busy at first attempt
    logic len_is_64;     // frame was exactly 64 bytes
  } tsf_report_t;
  // collision event during a transmission
  typedef struct packed {
    logic valid;         // one-cycle pulse per collision
    logic late;          // collision was late
  } tsf_coll_t;
  // jam generator states
  typedef enum logic [1:0] {
    TSF_IDLE = 2'h0,
    TSF_JAM = 2'h1
  } tsf_state_t;
endpackage : tsf_pkg

// ===== core/tsf_stats.sv
// transmit frame statistics counters with register read port
// assumes synchronous inputs, one-cycle event pulses, one clock
//
// Contract
// - count every clean transmitted frame as good
// - broadcast counter: clean frames to all ones
// - group counter: clean non-broadcast group frames
// - pause counter: mac-built pause frames only
// - pause count ignores errors, full duplex
// - pause frames also count group and 64-byte
// - deferred: waited, no collisions, clean frame
// - count each collision, late ones included
// - send jam on every non-late collision
// - collisions counted only without carrier loss/underrun
// - half duplex flow control rx start counts
// - single collision: exactly one, not late
// - counters are 32-bit read-only words
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "tsf_defines.svh"
module tsf_stats #(
  parameter int JAM_CYCLES = `TSF_JAM_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire tsf_pkg::tsf_report_t report_in,
  input wire tsf_pkg::tsf_coll_t coll_in,
  input wire logic half_duplex_in,
  input wire logic flow_ctrl_in,
  input wire logic rx_start_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic jam_out,
  output logic min_size_tick_out
);
  import tsf_pkg::*;

  // ==========================================================
  // elaboration checks
  if (JAM_CYCLES < 1 || JAM_CYCLES > 15)
  begin : g_chk
    $error("JAM_CYCLES must lie in 1..15");
  end

  // ==========================================================
  // frame classification
  // group bit of the first octet sent
  function automatic logic is_group(input logic [47:0] a);
    is_group = a[`TSF_GROUP_BIT];
  endfunction : is_group

  // all-ones destination
  function automatic logic is_bcast(input logic [47:0] a);
    is_bcast = (a == `TSF_BCAST_ADDR);
  endfunction : is_bcast

  logic clean;       // no late/excess collision, loss or underrun
  logic no_err;      // no carrier loss and no underrun
  logic [4:0] pend_q; // collisions seen in the current frame
  logic [4:0] pend_d;
  logic [4:0] pend_tot; // including one arriving this cycle
  logic [4:0] coll_add; // collisions credited this cycle
  logic [`TSF_NUM_CNT-1:0] inc; // increment per counter

  assign no_err = !report_in.carrier_loss && !report_in.underrun;
  assign clean = no_err && !report_in.late_coll
    && !report_in.excess_coll;
  assign pend_tot = pend_q + {4'h0, coll_in.valid};

  // ==========================================================
  // per-frame collision tally
  // collect events until the frame outcome is known
  always_comb
  begin
    if (report_in.valid)
    begin
      pend_d = 5'h00; // frame done, start afresh
    end
    else if (pend_tot == 5'h1F)
    begin
      pend_d = pend_q; // saturate, cannot happen legally
    end
    else
    begin
      pend_d = pend_tot;
    end
  end

  // tally register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pend_q <= 5'h00;
    end
    else if (ce_in)
    begin
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // increment decode
  // every counter hit by one frame moves in the same cycle
  always_comb
  begin
    inc = '0;
    coll_add = 5'h00;
    if (report_in.valid && clean)
    begin
      inc[`TSF_IDX_GOOD] = 1'b1;
      inc[`TSF_IDX_BCAST] = is_bcast(report_in.dest);
      inc[`TSF_IDX_GROUP] = is_group(report_in.dest)
        && !is_bcast(report_in.dest);
      inc[`TSF_IDX_DEFER] = report_in.deferred
        && (pend_tot == 5'h00);
      inc[`TSF_IDX_SCOLL] = (pend_tot == 5'h01);
    end
    if (report_in.valid && report_in.mac_pause && !half_duplex_in)
    begin
      // errors are impossible on mac-built pause frames
      inc[`TSF_IDX_PAUSE] = 1'b1;
      inc[`TSF_IDX_GROUP] = 1'b1;
    end
    if (report_in.valid && no_err)
    begin
      coll_add = pend_tot;
    end
    if (half_duplex_in && flow_ctrl_in && rx_start_in)
    begin
      coll_add = coll_add + 5'h01;
    end
    inc[`TSF_IDX_COLL] = (coll_add != 5'h00);
  end

  // 64-byte size statistic lives elsewhere; signal it
  assign min_size_tick_out = ce_in && report_in.valid
    && ((clean && report_in.len_is_64)
    || (report_in.mac_pause && !half_duplex_in));

  // ==========================================================
  // counter array
  logic [`TSF_CNT_W-1:0] cnt_q [`TSF_NUM_CNT];
  logic [`TSF_CNT_W-1:0] cnt_d [`TSF_NUM_CNT];

  // next counts, natural wrap at 32 bits
  always_comb
  begin
    for (int i = 0; i < `TSF_NUM_CNT; i++)
    begin
      if (i == int'(`TSF_IDX_COLL))
      begin
        cnt_d[i] = cnt_q[i] + {27'h0, coll_add};
      end
      else
      begin
        cnt_d[i] = cnt_q[i] + {31'h0, inc[i]};
      end
    end
  end

  // counter registers; software cannot write them
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `TSF_NUM_CNT; i++)
      begin
        cnt_q[i] <= `TSF_CNT_RST;
      end
    end
    else if (ce_in)
    begin
      for (int i = 0; i < `TSF_NUM_CNT; i++)
      begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // ==========================================================
  // jam generator
  tsf_state_t st_q; // jam state
  tsf_state_t st_d;
  logic [3:0] jam_q; // jam cycles left
  logic [3:0] jam_d;

  // start or restart jam on a non-late collision
  always_comb
  begin
    st_d = st_q;
    jam_d = jam_q;
    if (coll_in.valid && !coll_in.late)
    begin
      st_d = TSF_JAM;
      jam_d = 4'(JAM_CYCLES - 1);
    end
    else
    begin
      unique case (st_q)
        TSF_IDLE:
        begin
          jam_d = 4'h0;
        end
        TSF_JAM:
        begin
          if (jam_q == 4'h0)
          begin
            st_d = TSF_IDLE; // jam finished
          end
          else
          begin
            jam_d = jam_q - 4'h1;
          end
        end
        default:
        begin
          st_d = TSF_IDLE; // illegal code recovers
        end
      endcase
    end
  end

  // jam registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= TSF_IDLE;
      jam_q <= 4'h0;
    end
    else if (ce_in)
    begin
      st_q <= st_d;
      jam_q <= jam_d;
    end
  end

  assign jam_out = (st_q == TSF_JAM);

  // ==========================================================
  // register read port
  logic [31:0] rdata_q; // read data, valid one cycle after strobe
  logic [31:0] rdata_d;
  logic unused_wr; // writes have no effect

  assign unused_wr = wr_in ^ (^wdata_in);

  // decode; unmapped addresses read as zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd_in)
    begin
      unique case (addr_in)
        `TSF_OFF_GOOD: rdata_d = cnt_q[`TSF_IDX_GOOD];
        `TSF_OFF_BCAST: rdata_d = cnt_q[`TSF_IDX_BCAST];
        `TSF_OFF_GROUP: rdata_d = cnt_q[`TSF_IDX_GROUP];
        `TSF_OFF_PAUSE: rdata_d = cnt_q[`TSF_IDX_PAUSE];
        `TSF_OFF_DEFER: rdata_d = cnt_q[`TSF_IDX_DEFER];
        `TSF_OFF_COLL: rdata_d = cnt_q[`TSF_IDX_COLL];
        `TSF_OFF_SCOLL: rdata_d = cnt_q[`TSF_IDX_SCOLL];
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;

  // ==========================================================
  // assertions
  property p_good;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && report_in.valid && clean |=>
      cnt_q[0] == $past(cnt_q[0]) + 32'h1;
  endproperty
  a_good: assert property (p_good) else $error("good missed");

  property p_bcast;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !(report_in.valid && clean
      && is_bcast(report_in.dest)) |=> $stable(cnt_q[1]);
  endproperty
  a_bcast: assert property (p_bcast) else $error("bcast bad");

  property p_group;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && report_in.valid && clean && is_bcast(report_in.dest)
      && !report_in.mac_pause |=> $stable(cnt_q[2]);
  endproperty
  a_group: assert property (p_group) else $error("group bad");

  property p_pause;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && report_in.valid && report_in.mac_pause
      && !half_duplex_in |=> cnt_q[3] == $past(cnt_q[3]) + 32'h1
      && cnt_q[2] == $past(cnt_q[2]) + 32'h1;
  endproperty
  a_pause: assert property (p_pause) else $error("pause bad");

  property p_defer;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && report_in.valid && pend_tot != 5'h00 |=>
      $stable(cnt_q[4]);
  endproperty
  a_defer: assert property (p_defer) else $error("defer bad");

  property p_coll;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && report_in.valid && !no_err
      && !(half_duplex_in && flow_ctrl_in && rx_start_in)
      |=> $stable(cnt_q[5]);
  endproperty
  a_coll: assert property (p_coll) else $error("coll bad");

  property p_rxcoll;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && half_duplex_in && flow_ctrl_in && rx_start_in
      && !report_in.valid |=> cnt_q[5] == $past(cnt_q[5]) + 32'h1;
  endproperty
  a_rxcoll: assert property (p_rxcoll) else $error("rx coll");

  property p_jam;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && coll_in.valid && !coll_in.late |=> jam_out;
  endproperty
  a_jam: assert property (p_jam) else $error("no jam");

  property p_scoll;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && report_in.valid && pend_tot > 5'h01 |=>
      $stable(cnt_q[6]);
  endproperty
  a_scoll: assert property (p_scoll) else $error("scoll bad");

  property p_read;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_in && addr_in == `TSF_OFF_GOOD |=>
      rdata_out == $past(cnt_q[0]);
  endproperty
  a_read: assert property (p_read) else $error("read bad");

  c_pause: cover property (@(posedge clk_in)
    report_in.valid && report_in.mac_pause);
  c_scoll: cover property (@(posedge clk_in)
    inc[`TSF_IDX_SCOLL]);
  c_jam: cover property (@(posedge clk_in) jam_out ##1 !jam_out);
endmodule : tsf_stats

// ===== verification/tsf_tx_model.sv
// transmit path stand-in: collision pulses, then one frame report
// assumes go_in is a one-cycle pulse given while busy_out is low
`timescale 1ns/1ps
module tsf_tx_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [3:0] n_coll_in,
  input wire logic late_in,
  input wire tsf_pkg::tsf_report_t frame_in,
  output tsf_pkg::tsf_report_t report_out,
  output tsf_pkg::tsf_coll_t coll_out,
  output logic busy_out
);
  import tsf_pkg::*;
  int i; // collision index
  // ==========================================================
  // attempt loop
  // one pulse per attempt, a gap, report after the last one
  initial
  begin
    report_out = '0;
    coll_out = '0;
    busy_out = 1'b0;
    forever
    begin
      @(posedge clk_in);
      if (go_in)
      begin
        busy_out <= 1'b1;
        for (i = 0; i < int'(n_coll_in); i++)
        begin
          coll_out <= {1'b1, late_in && (i == int'(n_coll_in) - 1)};
          @(posedge clk_in);
          coll_out <= '0;
          @(posedge clk_in);
        end
        report_out <= frame_in;
        @(posedge clk_in);
        // released fields show junk, not the old frame
        report_out <= {1'b0, ~frame_in[$bits(frame_in)-2:0]};
        busy_out <= 1'b0;
      end
    end
  end
endmodule : tsf_tx_model

// ===== verification/test_tsf_stats.sv
// bench for the transmit statistics counters
// assumes tsf_tx_model as the transmit path, one 50 MHz clock
`timescale 1ns/1ps
module test_tsf_stats;
  import tsf_pkg::*;
  localparam int JAM = 3; // shortened jam length
  localparam logic [47:0] UC = 48'h0200_0000_0001;
  localparam logic [47:0] MC = 48'h0100_5E00_0001;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] PZ = 48'h0180_C200_0001;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic half_duplex_in = 1'b0;
  logic flow_ctrl_in = 1'b0;
  logic rx_start_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic jam_out;
  logic min_size_tick_out;
  tsf_report_t report_in;
  tsf_report_t frame_r = '0; // frame handed to the model
  tsf_coll_t coll_in;
  logic go_r = 1'b0;
  logic [3:0] ncoll_r = 4'h0;
  logic late_r = 1'b0;
  logic busy;
  logic [31:0] exp_cnt [7]; // expected counters
  int n_errors = 0;
  int n_tests = 0;
  int jam_n = 0; // jam cycles seen
  int tick_n = 0; // size ticks seen
  int tick_e = 0;
  int k;
  always #10 clk_in = ~clk_in;
  tsf_stats #(.JAM_CYCLES(JAM)) u_dut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .ce_in(ce_in), .report_in(report_in),
    .coll_in(coll_in), .half_duplex_in(half_duplex_in),
    .flow_ctrl_in(flow_ctrl_in), .rx_start_in(rx_start_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .jam_out(jam_out),
    .min_size_tick_out(min_size_tick_out));
  tsf_tx_model u_mac (.clk_in(clk_in), .go_in(go_r),
    .n_coll_in(ncoll_r), .late_in(late_r), .frame_in(frame_r),
    .report_out(report_in), .coll_out(coll_in), .busy_out(busy));
  // ==========================================================
  // monitors: jam length and size ticks
  always @(posedge clk_in)
  begin
    if (jam_out === 1'b1)
      jam_n++;
    if (min_size_tick_out === 1'b1 && ce_in)
      tick_n++;
  end
  // ==========================================================
  // tasks
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  // one read: strobe one cycle, data in the next
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd
  task automatic wr(input logic [7:0] a);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= 32'hFFFF_FFFF;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic chk_all;
    logic [31:0] v;
    for (int i = 0; i < 7; i++)
    begin
      rd(8'(4 * i), v);
      cmp($sformatf("counter %0d", i), exp_cnt[i], v);
    end
  endtask : chk_all
  function automatic tsf_report_t fr(input logic [47:0] d,
                                     input logic [6:0] fl);
    return {1'b1, d, fl};
  endfunction : fr
  // one frame through the model, expectations from its outcome
  task automatic frame(input tsf_report_t f, input int n,
                       input logic lt, input int jam_e);
    logic cl;
    logic pz;
    @(posedge clk_in);
    cl = !(f.late_coll | f.excess_coll | f.carrier_loss | f.underrun);
    pz = f.mac_pause & !half_duplex_in;
    if (ce_in)
    begin
      exp_cnt[0] += {31'h0, cl};
      exp_cnt[1] += {31'h0, cl && f.dest == BC};
      exp_cnt[2] += {31'h0, (cl | f.mac_pause) && f.dest[40]
                            && f.dest != BC};
      exp_cnt[3] += {31'h0, pz};
      exp_cnt[4] += {31'h0, cl && f.deferred && n == 0};
      if (!(f.carrier_loss | f.underrun))
        exp_cnt[5] += 32'(n);
      exp_cnt[6] += {31'h0, cl && n == 1 && !lt};
      tick_e += int'((cl && f.len_is_64) || pz);
    end
    jam_n = 0;
    frame_r <= f;
    ncoll_r <= 4'(n);
    late_r <= lt;
    go_r <= 1'b1;
    @(posedge clk_in);
    go_r <= 1'b0;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk_in);
      #1;
      if (!busy)
        break;
    end
    if (k == 200)
    begin
      n_errors++;
      test_done();
    end
    repeat (JAM + 2) @(posedge clk_in);
    if (jam_e >= 0)
      cmp("jam cycles", 32'(jam_e), 32'(jam_n));
  endtask : frame
  task automatic rxp(input logic fc);
    @(posedge clk_in);
    flow_ctrl_in <= fc;
    rx_start_in <= 1'b1;
    @(posedge clk_in);
    rx_start_in <= 1'b0;
    exp_cnt[5] += {31'h0, fc & half_duplex_in};
  endtask : rxp
  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] v;
    foreach (exp_cnt[i])
      exp_cnt[i] = 32'h0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk_all();
    rd(8'h1C, v);
    cmp("unmapped", 32'h0, v);
    frame(fr(UC, 7'h01), 0, 1'b0, 0);
    frame(fr(BC, 7'h00), 0, 1'b0, 0);
    frame(fr(MC, 7'h00), 0, 1'b0, 0);
    frame(fr(PZ, 7'h49), 0, 1'b0, 0);
    frame(fr(PZ, 7'h01), 0, 1'b0, 0);
    frame(fr(UC, 7'h04), 0, 1'b0, 0);
    frame(fr(UC, 7'h04), 1, 1'b0, JAM);
    frame(fr(MC, 7'h00), 2, 1'b0, -1);
    frame(fr(UC, 7'h20), 1, 1'b1, 0);
    frame(fr(UC, 7'h10), 1, 1'b0, JAM);
    frame(fr(BC, 7'h08), 3, 1'b0, -1);
    chk_all();
    ce_in <= 1'b0;
    frame(fr(UC, 7'h00), 1, 1'b0, -1);
    ce_in <= 1'b1;
    half_duplex_in <= 1'b1;
    frame(fr(PZ, 7'h41), 0, 1'b0, -1);
    rxp(1'b0);
    rxp(1'b1);
    half_duplex_in <= 1'b0;
    rxp(1'b1);
    for (int i = 0; i < 8; i++)
      wr(8'(4 * i));
    chk_all();
    cmp("size ticks", 32'(tick_e), 32'(tick_n));
    test_done();
  end
endmodule : test_tsf_stats
